// ### design/apd_top.sv
// Aperture delay adjust: delay and ramp registers over the register
// port, selection of manual or calibration values, coarse ramping.
// Assumes a word-wide synchronous register port in the mclk domain.
`timescale 1ns/1ps
module apd_top (
  input  wire logic        mclk,               // Sampling clock
  input  wire logic        srst,               // Sync reset, high
  input  wire logic        reg_wr,             // Write strobe
  input  wire logic        reg_rd,             // Read strobe
  input  wire logic [11:0] reg_addr,           // Register offset
  input  wire logic [23:0] reg_wdata,          // Write data
  output logic      [23:0] reg_rdata,          // Read data, registered
  input  wire logic        sysref_cal_enable,  // Calibration owns delay
  input  wire logic [16:0] cal_delay_result,   // Calibration result
  output logic             sample_clock_invert,// Applied inversion
  output logic      [7:0]  coarse_delay_code,  // Applied coarse code
  output logic      [7:0]  fine_delay_code,    // Applied fine code
  output logic             ramp_busy           // Coarse ramp in progress
);
  logic [23:0] dly_q, dly_d;     // Delay register
  logic [7:0]  rmp_q, rmp_d;     // Ramp control register
  logic [23:0] rd_q, rd_d;       // Read data
  logic [7:0]  man_coarse;       // Ramped manual coarse code
  logic        man_busy;         // Ramp not settled
  logic        wr_dly, wr_rmp;   // Decoded writes

  assign wr_dly = reg_wr && reg_addr == apd_pkg::APD_DELAY_OFS;
  assign wr_rmp = reg_wr && reg_addr == apd_pkg::APD_RAMP_OFS;

  // Register write and read decode
  always_comb begin
    dly_d = dly_q;
    rmp_d = rmp_q;
    rd_d  = rd_q;
    // Reserved bits stay zero
    if (wr_dly) dly_d = {7'h00, reg_wdata[16:0]};
    if (wr_rmp) rmp_d = {6'h00, reg_wdata[1:0]};
    if (reg_rd) begin
      case (reg_addr)
        apd_pkg::APD_DELAY_OFS: rd_d = dly_q;
        apd_pkg::APD_RAMP_OFS:  rd_d = {16'h0000, rmp_q};
        default:                rd_d = 24'h000000;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      dly_q <= apd_pkg::APD_DELAY_RST;
      rmp_q <= apd_pkg::APD_RAMP_RST;
      rd_q  <= 24'h000000;
    end else begin
      dly_q <= dly_d;
      rmp_q <= rmp_d;
      rd_q  <= rd_d;
    end
  end

  // Coarse ramp engine
  apd_ramp u_ramp (
    .mclk      (mclk),
    .srst      (srst),
    .target    (dly_q[apd_pkg::APD_CRS_LSB +: 8]),
    .ramp_en   (rmp_q[apd_pkg::APD_RAMP_EN_BIT]),
    .ramp_fast (rmp_q[apd_pkg::APD_RAMP_RATE_BIT]),
    .applied   (man_coarse),
    .busy      (man_busy)
  );

  logic        inv_q, inv_d;     // Applied inversion
  logic [7:0]  crs_q, crs_d;     // Applied coarse
  logic [7:0]  fin_q, fin_d;     // Applied fine

  // Select applied delay source
  always_comb begin
    if (sysref_cal_enable) begin
      inv_d = cal_delay_result[apd_pkg::APD_INV_BIT];
      crs_d = cal_delay_result[apd_pkg::APD_CRS_LSB +: 8];
      fin_d = cal_delay_result[apd_pkg::APD_FINE_LSB +: 8];
    end else begin
      inv_d = dly_q[apd_pkg::APD_INV_BIT];
      crs_d = man_coarse;
      fin_d = dly_q[apd_pkg::APD_FINE_LSB +: 8];
    end
  end

  // Register applied outputs
  always_ff @(posedge mclk) begin
    if (srst) begin
      inv_q <= 1'b0;
      crs_q <= 8'h00;
      fin_q <= 8'h00;
    end else begin
      inv_q <= inv_d;
      crs_q <= crs_d;
      fin_q <= fin_d;
    end
  end

  assign sample_clock_invert = inv_q;
  assign coarse_delay_code   = crs_q;
  assign fine_delay_code     = fin_q;
  assign ramp_busy           = man_busy;
  assign reg_rdata           = rd_q;

  a_inv_follow: assert property (
    @(posedge mclk) disable iff (srst)
    !sysref_cal_enable |=>
    sample_clock_invert == $past(dly_q[apd_pkg::APD_INV_BIT]))
    else $error("inversion does not follow register");
  // fine applied two cycles after write
  a_fine_now: assert property (
    @(posedge mclk) disable iff (srst)
    (wr_dly && !sysref_cal_enable) ##1 !sysref_cal_enable |=>
    fine_delay_code == $past(reg_wdata[7:0], 2))
    else $error("fine code not applied promptly");
  a_cal_select: assert property (
    @(posedge mclk) disable iff (srst)
    sysref_cal_enable |=> coarse_delay_code == $past(cal_delay_result[15:8])
    && fine_delay_code == $past(cal_delay_result[7:0]))
    else $error("calibration delay not applied");
  a_cal_invert: assert property (
    @(posedge mclk) disable iff (srst)
    sysref_cal_enable |=>
    sample_clock_invert == $past(cal_delay_result[apd_pkg::APD_INV_BIT]))
    else $error("calibration inversion not applied");
  // a running ramp moves or settles each interval
  a_ramp_moves: assert property (
    @(posedge mclk) disable iff (srst)
    ramp_busy |-> ##[1:384]
    (!ramp_busy || man_coarse != $past(man_coarse)))
    else $error("coarse ramp stalled");
  a_coarse_man: assert property (
    @(posedge mclk) disable iff (srst)
    !sysref_cal_enable |=> coarse_delay_code == $past(man_coarse))
    else $error("manual coarse not applied");
  a_coarse_direct: assert property (
    @(posedge mclk) disable iff (srst)
    (wr_dly && !rmp_q[0] && !sysref_cal_enable) ##1
    (!rmp_q[0] && !sysref_cal_enable) ##1
    (!rmp_q[0] && !sysref_cal_enable) |=>
    coarse_delay_code == $past(reg_wdata[15:8], 3))
    else $error("coarse code late without ramp");
endmodule // apd_top

// ### design/apd_pkg.sv
// Constants for the aperture delay adjust block: register map, fields,
// reset values and ramp timing. Assumes a 200 MHz mclk.
package apd_pkg;
  // Register offsets
  localparam logic [11:0] APD_DELAY_OFS = 12'h2b5;
  localparam logic [11:0] APD_RAMP_OFS  = 12'h2b8;
  // Field positions of the delay word
  localparam int APD_INV_BIT   = 16;
  localparam int APD_CRS_LSB   = 8;
  localparam int APD_FINE_LSB  = 0;
  // Field positions of the ramp control byte
  localparam int APD_RAMP_EN_BIT   = 0;
  localparam int APD_RAMP_RATE_BIT = 1;
  // Reset values
  localparam logic [23:0] APD_DELAY_RST = 24'h000000;
  localparam logic [7:0]  APD_RAMP_RST  = 8'h00;
  // Step sizes in codes
  localparam logic [7:0] APD_STEP_SLOW = 8'h01;
  localparam logic [7:0] APD_STEP_FAST = 8'h04;
  // Ramp interval in sampling clock cycles
  localparam int APD_RAMP_CYC = 384;
  // Direct-update deadline; we apply fine in two cycles and coarse in three, well inside it
  localparam int APD_DIRECT_MAX_CYC = 1536;
  // Clock period in ps, for reference
  localparam int APD_CLK_PS = 5000;
  localparam int APD_RAMP_NS = APD_RAMP_CYC * APD_CLK_PS / 1000;
  // Ramp timer width
  localparam int APD_TMR_W = 9;
  localparam logic [8:0] APD_TMR_LAST = 9'(APD_RAMP_CYC - 1);
endpackage

// ### design/apd_ramp.sv
// Coarse code ramp engine: walks applied code toward a target.
// Assumes target and controls come from registers in mclk domain.
`timescale 1ns/1ps
module apd_ramp (
  input  wire logic       mclk,        // Sampling-domain clock
  input  wire logic       srst,        // Synchronous reset, high
  input  wire logic [7:0] target,      // Written coarse code
  input  wire logic       ramp_en,     // Ramp enable
  input  wire logic       ramp_fast,   // Four codes per step when high
  output logic      [7:0] applied,     // Applied coarse code
  output logic            busy         // Applied differs from target
);
  logic [8:0] tmr_q, tmr_d;            // Interval timer
  logic [7:0] app_q, app_d;            // Applied code
  logic [7:0] step;                    // Step size
  logic [7:0] diff_up, diff_dn;        // Distance to target

  // Next state of timer and applied code
  always_comb begin
    step    = ramp_fast ? apd_pkg::APD_STEP_FAST : apd_pkg::APD_STEP_SLOW;
    diff_up = target - app_q;
    diff_dn = app_q - target;
    tmr_d   = tmr_q;
    app_d   = app_q;
    if (!ramp_en) begin
      app_d = target;
      tmr_d = '0;
    end else if (app_q == target) begin
      // Idle; restart interval on next change
      tmr_d = '0;
    end else if (tmr_q == apd_pkg::APD_TMR_LAST) begin
      tmr_d = '0;
      if (target > app_q) begin
        app_d = (diff_up < step) ? target : app_q + step;
      end else begin
        app_d = (diff_dn < step) ? target : app_q - step;
      end
    end else begin
      tmr_d = tmr_q + 9'h001;
    end
  end

  // Register the ramp state
  always_ff @(posedge mclk) begin
    if (srst) begin
      tmr_q <= '0;
      app_q <= '0;
    end else begin
      tmr_q <= tmr_d;
      app_q <= app_d;
    end
  end

  assign applied = app_q;
  assign busy    = (app_q != target);

  a_direct_apply: assert property (
    @(posedge mclk) disable iff (srst)
    !ramp_en |=> (app_q == $past(target)))
    else $error("coarse code not applied directly");
  a_ramp_hold: assert property (
    @(posedge mclk) disable iff (srst)
    (ramp_en && $past(ramp_en) && tmr_q != apd_pkg::APD_TMR_LAST)
    |=> $stable(app_q))
    else $error("coarse code moved between steps");
  a_step_size: assert property (
    @(posedge mclk) disable iff (srst)
    (ramp_en && tmr_q == apd_pkg::APD_TMR_LAST && !ramp_fast
     && app_q != target) |=>
    (app_q - $past(app_q) == 8'h01 || $past(app_q) - app_q == 8'h01))
    else $error("slow ramp step not one code");
  // fast step moves one to four codes
  a_fast_step: assert property (
    @(posedge mclk) disable iff (srst)
    (ramp_en && tmr_q == apd_pkg::APD_TMR_LAST && ramp_fast
     && app_q != target) |=>
    (8'(app_q - $past(app_q)) inside {[8'h01:8'h04]} ||
     8'($past(app_q) - app_q) inside {[8'h01:8'h04]}))
    else $error("fast ramp step out of range");
endmodule // apd_ramp

// ### tb/apd_top_tb.sv
// Self-checking bench for the aperture delay block: register rows,
// calibration override and coarse ramping. Needs apd_pkg and apd_top.
`timescale 1ns/1ps
module apd_top_tb;
  logic        mclk = 1'b0;            // 200 MHz sampling clock
  logic        srst = 1'b1;            // Sync reset, high
  logic        reg_wr = 1'b0;          // Write strobe
  logic        reg_rd = 1'b0;          // Read strobe
  logic [11:0] reg_addr = 12'h000;     // Register offset
  logic [23:0] reg_wdata = 24'h000000; // Write data
  logic [23:0] reg_rdata;              // Read data
  logic        sysref_cal_enable = 1'b0; // Calibration select
  logic [16:0] cal_delay_result = 17'h00000; // Calibration value
  logic        sample_clock_invert;    // Applied inversion
  logic [7:0]  coarse_delay_code;      // Applied coarse
  logic [7:0]  fine_delay_code;        // Applied fine
  logic        ramp_busy;              // Ramp running
  logic [23:0] got;                    // Read-back holder
  int          mismatches = 0;         // Failed checks
  int          compares = 0;           // All checks
  // Table rows: written word, expected read-back and outputs
  logic [23:0] row_wd [4] = '{24'h010203, 24'hfe80ff, 24'h01ff00,
                              24'h000001};
  logic [23:0] row_rd [4] = '{24'h010203, 24'h0080ff, 24'h01ff00,
                              24'h000001};
  apd_top i_apd_top (.mclk(mclk), .srst(srst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .sysref_cal_enable(sysref_cal_enable),
    .cal_delay_result(cal_delay_result),
    .sample_clock_invert(sample_clock_invert),
    .coarse_delay_code(coarse_delay_code),
    .fine_delay_code(fine_delay_code), .ramp_busy(ramp_busy));
  // Free-running clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  // Counts a check and reports a mismatch
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle write pulse
  task automatic wr(input logic [11:0] a, input logic [23:0] d);
    @(negedge mclk);
    reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask
  // One-cycle read pulse, data taken a cycle later
  task automatic rd(input logic [11:0] a, output logic [23:0] d);
    @(negedge mclk);
    reg_rd = 1'b1; reg_addr = a;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask
  // Bounded wait for the ramp to settle
  task automatic wait_idle();
    int n;
    n = 0;
    while (ramp_busy !== 1'b0 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    // Applied coarse is registered one cycle behind the ramp
    @(negedge mclk);
    chk({23'h0, ramp_busy}, 24'h000000);
  endtask
  // Applied outputs packed like the delay word
  function automatic logic [23:0] outs();
    return {7'h00, sample_clock_invert, coarse_delay_code,
            fine_delay_code};
  endfunction
  // Prints counts and verdict, then stops
  task automatic conclude();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #(20000 * 5);
    mismatches++;
    conclude();
  end
  initial begin
    repeat (20) @(negedge mclk);
    srst = 1'b0;
    rd(apd_pkg::APD_DELAY_OFS, got);
    chk(got, apd_pkg::APD_DELAY_RST);
    rd(apd_pkg::APD_RAMP_OFS, got);
    chk(got, {16'h0, apd_pkg::APD_RAMP_RST});
    rd(12'h2b6, got);
    chk(got, 24'h000000);
    chk(outs(), 24'h000000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(apd_pkg::APD_DELAY_OFS, row_wd[i]);
      repeat (3) @(negedge mclk);
      rd(apd_pkg::APD_DELAY_OFS, got);
      chk(got, row_rd[i]);
      chk(outs(), row_rd[i]);
    end
    $display("test rows done");
    sysref_cal_enable = 1'b1; cal_delay_result = 17'h1a5c3;
    repeat (3) @(negedge mclk);
    chk(outs(), 24'h01a5c3);
    sysref_cal_enable = 1'b0;
    repeat (4) @(negedge mclk);
    chk(outs(), 24'h000001);
    $display("test calibration done");
    wr(apd_pkg::APD_RAMP_OFS, 24'h0000ff);
    rd(apd_pkg::APD_RAMP_OFS, got);
    chk(got, 24'h000003);
    wr(apd_pkg::APD_RAMP_OFS, 24'h000001);
    wr(apd_pkg::APD_DELAY_OFS, 24'h000305);
    repeat (2) @(negedge mclk);
    chk(outs(), 24'h000005);
    chk({23'h0, ramp_busy}, 24'h000001);
    repeat (373) @(negedge mclk);
    chk(outs(), 24'h000005);
    repeat (15) @(negedge mclk);
    chk(outs(), 24'h000105);
    wait_idle();
    chk(outs(), 24'h000305);
    wr(apd_pkg::APD_RAMP_OFS, 24'h000003);
    wr(apd_pkg::APD_DELAY_OFS, 24'h000a05);
    repeat (390) @(negedge mclk);
    chk(outs(), 24'h000705);
    wait_idle();
    chk(outs(), 24'h000a05);
    wr(apd_pkg::APD_DELAY_OFS, 24'h000405);
    repeat (390) @(negedge mclk);
    chk(outs(), 24'h000605);
    wait_idle();
    chk(outs(), 24'h000405);
    $display("test ramp done");
    // Mid-run reset clears registers and outputs
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    chk(outs(), 24'h000000);
    rd(apd_pkg::APD_RAMP_OFS, got);
    chk(got, {16'h0, apd_pkg::APD_RAMP_RST});
    $display("test mid reset done");
    conclude();
  end
endmodule // apd_top_tb
